/* core/hwm_core.v */
// Monitoring core: measurement sequencer, limit status, alert pins, address pointer, slave address
//
// Functional notes
// - All control and programming goes through the single management bus slave port.
// - Either of two multi-purpose pins can be enabled as open-drain alert output.
// - When started, measure voltage then each temperature channel, storing each value.
// - Compare each value with its limits; out-of-limit sets a readable status bit.
// - An enabled alert pin is driven low while any unmasked status bit is set.
// - One mask bit per status event keeps that event off the alert pins.
// - Address-enable strap low: slave address follows the address-select strap.
// - Address-enable strap high: slave address is the default 0x2E.
// - A write to the pointer register stores the byte selecting later data accesses.
// - A signed two's complement offset per channel is added to each temperature.
// - A programmable fan start temperature is held for each fan.
// - A programmable temperature range is held for each fan drive output.
// - A programmable target operating temperature is held for each thermal zone.
// - Acoustic enhancement settings are held for each fan drive output.
// - Select mode: address 0x2C with select strap low, 0x2D with it high.
// - Slave address latches on the first matching transaction, later pin changes ignored.
`default_nettype none
`include "hwm_defines.vh"

module hwm_core (
    input  wire        hclk,
    input  wire        hresetn,
    input  wire        ce,
    input  wire        hsel,
    input  wire [31:0] haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire [2:0]  hsize,
    input  wire [31:0] hwdata,
    input  wire        hready,
    output reg  [31:0] hrdata,
    output reg         hreadyout,
    output reg         hresp,
    output reg         irq,
    output reg         adc_start,
    output reg  [1:0]  adc_chan,
    input  wire [7:0]  adc_data,
    input  wire        adc_valid,
    input  wire        addr_en_pin,
    input  wire        addr_sel_pin,
    input  wire        addr_match,
    output reg  [6:0]  slave_addr,
    output reg         slave_addr_locked,
    output reg         alert_a_o,
    output reg         alert_a_oe,
    output reg         alert_b_o,
    output reg         alert_b_oe
);

    localparam [1:0] S_IDLE  = 2'd0;
    localparam [1:0] S_START = 2'd1;
    localparam [1:0] S_WAIT  = 2'd2;

    // Bus front end
    reg        wr_pend_r;
    reg        rd_pend_r;
    reg [7:0]  acc_addr_r;
    wire       take;
    wire       word_ok;

    // Software state
    reg [2:0]  ctrl_r;
    reg [2:0]  ctrl_nxt;
    reg [7:0]  ptr_r;
    reg [3:0]  stat_r;
    reg [3:0]  mask_r;
    reg [3:0]  mask_nxt;
    reg [31:0] val_r;
    reg [7:0]  prog_mem [0:`HWM_PROG_DEPTH-1];

    // Sequencer
    reg [1:0]  state_r;
    reg [1:0]  state_nxt;
    reg [1:0]  chan_r;

    // Datapath
    reg [7:0]  corr_nxt;
    reg [8:0]  sum;
    reg [7:0]  lim_lo;
    reg [7:0]  lim_hi;
    reg [7:0]  offs;
    reg        out_of_lim;
    reg [3:0]  stat_set;
    reg [3:0]  stat_clr;
    reg [3:0]  stat_nxt;
    reg [31:0] rd_nxt;
    reg [7:0]  prog_rd;
    wire       ptr_in_range;
    wire [1:0] strap_s;
    reg [1:0]  strap_fill_r;
    reg        alert_nxt;
    integer    i;

    hwm_sync #(
        .W       (2)
    ) u_strap_sync (
        .hclk    (hclk),
        .hresetn (hresetn),
        .ce      (ce),
        .d       ({addr_sel_pin, addr_en_pin}),
        .q       (strap_s)
    );

    // Bus slave: writes complete in their data phase, reads add one wait state
    assign take    = hsel & hready & htrans[1];
    assign word_ok = (hsize == 3'b010) && (haddr[1:0] == 2'b00);

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_r  <= 1'b0;
            rd_pend_r  <= 1'b0;
            acc_addr_r <= 8'h00;
            hreadyout  <= 1'b1;
            hresp      <= 1'b0;
            hrdata     <= 32'h0000_0000;
        end else if (ce) begin
            wr_pend_r <= take & hwrite & word_ok;
            if (take) begin
                acc_addr_r <= haddr[7:0];
            end
            if (take && !hwrite) begin
                rd_pend_r <= 1'b1;
                hreadyout <= 1'b0;
            end else if (rd_pend_r) begin
                rd_pend_r <= 1'b0;
                hreadyout <= 1'b1;
                hrdata    <= rd_nxt;
            end
        end
    end

    // Pointer past the programming bytes: reads give zero, writes are dropped
    assign ptr_in_range = ({24'h000000, ptr_r} < `HWM_PROG_DEPTH);

    always @* begin
        prog_rd = 8'h00;
        if (ptr_in_range) begin
            prog_rd = prog_mem[ptr_r[4:0]];
        end
    end

    // Read mux, loaded into hrdata in the wait state
    always @* begin
        rd_nxt = 32'h0000_0000;
        case (acc_addr_r)
            `HWM_OFS_CTRL: rd_nxt = {29'h0, ctrl_r};
            `HWM_OFS_PTR:  rd_nxt = {24'h0, ptr_r};
            `HWM_OFS_DATA: rd_nxt = {24'h0, prog_rd};
            `HWM_OFS_STAT: rd_nxt = {28'h0, stat_r};
            `HWM_OFS_MASK: rd_nxt = {28'h0, mask_r};
            `HWM_OFS_VAL:  rd_nxt = val_r;
            `HWM_OFS_ADDR: rd_nxt = {24'h0, slave_addr_locked, slave_addr};
            default:       rd_nxt = 32'h0000_0000;
        endcase
    end

    // Next control and mask, so irq and alert pins follow a write at the same edge
    always @* begin
        ctrl_nxt = ctrl_r;
        mask_nxt = mask_r;
        if (wr_pend_r && acc_addr_r == `HWM_OFS_CTRL) begin
            ctrl_nxt = hwdata[2:0];
        end
        if (wr_pend_r && acc_addr_r == `HWM_OFS_MASK) begin
            mask_nxt = hwdata[3:0];
        end
    end

    // Control, pointer and mask registers
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_r <= `HWM_CTRL_RST;
            ptr_r  <= `HWM_PTR_RST;
            mask_r <= `HWM_MASK_RST;
        end else if (ce && wr_pend_r) begin
            case (acc_addr_r)
                `HWM_OFS_CTRL: ctrl_r <= ctrl_nxt;
                `HWM_OFS_PTR:  ptr_r  <= hwdata[7:0];
                `HWM_OFS_MASK: mask_r <= mask_nxt;
                default:       ctrl_r <= ctrl_r;
            endcase
        end
    end

    // Programming bytes reached through the pointer: limits, offsets, fan settings
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (i = 0; i < `HWM_PROG_DEPTH; i = i + 1) begin
                prog_mem[i] <= 8'h00;
            end
            prog_mem[`HWM_IDX_LIM_LO] <= `HWM_VLIM_LO_RST;
            prog_mem[`HWM_IDX_LIM_HI] <= `HWM_VLIM_HI_RST;
            for (i = 1; i < 4; i = i + 1) begin
                prog_mem[`HWM_IDX_LIM_LO + i] <= `HWM_TLIM_LO_RST;
                prog_mem[`HWM_IDX_LIM_HI + i] <= `HWM_TLIM_HI_RST;
            end
        end else if (ce && wr_pend_r && acc_addr_r == `HWM_OFS_DATA && ptr_in_range) begin
            prog_mem[ptr_r[4:0]] <= hwdata[7:0];
        end
    end

    // Limit selection and offset correction for the channel in flight
    always @* begin
        lim_lo     = prog_mem[`HWM_IDX_LIM_LO + {3'b000, chan_r}];
        lim_hi     = prog_mem[`HWM_IDX_LIM_HI + {3'b000, chan_r}];
        offs       = 8'h00;
        sum        = 9'h000;
        corr_nxt   = adc_data;
        out_of_lim = 1'b0;
        // Temperature channels: offset, saturation, signed limits
        if (chan_r != 2'd0) begin
            offs = prog_mem[`HWM_IDX_OFFSET + {3'b000, chan_r} - 5'd1];
            sum  = {adc_data[7], adc_data} + {offs[7], offs};
            if (sum[8] != sum[7]) begin
                corr_nxt = sum[8] ? 8'h80 : 8'h7f;
            end else begin
                corr_nxt = sum[7:0];
            end
            out_of_lim = ($signed(corr_nxt) < $signed(lim_lo)) ||
                         ($signed(corr_nxt) > $signed(lim_hi));
        end else begin
            out_of_lim = (corr_nxt < lim_lo) || (corr_nxt > lim_hi);
        end
    end

    // Sequencer
    always @* begin
        state_nxt = state_r;
        case (state_r)
            S_IDLE: begin
                if (ctrl_r[`HWM_CTRL_RUN]) begin
                    state_nxt = S_START;
                end
            end
            S_START: begin
                state_nxt = S_WAIT;
            end
            S_WAIT: begin
                if (adc_valid) begin
                    state_nxt = ctrl_r[`HWM_CTRL_RUN] ? S_START : S_IDLE;
                end
            end
            default: begin
                state_nxt = S_IDLE;
            end
        endcase
    end

    // Channel counter, conversion request and value capture
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_r   <= S_IDLE;
            chan_r    <= 2'd0;
            adc_start <= 1'b0;
            adc_chan  <= 2'd0;
            val_r     <= 32'h0000_0000;
        end else if (ce) begin
            state_r   <= state_nxt;
            adc_start <= (state_r == S_START);
            adc_chan  <= chan_r;
            if (state_r == S_IDLE && ctrl_r[`HWM_CTRL_RUN]) begin
                chan_r <= 2'd0;
            end
            if (state_r == S_WAIT && adc_valid) begin
                val_r[8*chan_r +: 8] <= corr_nxt;
                if (chan_r == `HWM_LAST_CHAN) begin
                    chan_r <= 2'd0;
                end else begin
                    chan_r <= chan_r + 2'd1;
                end
            end
        end
    end

    // Sticky status: a new event wins over a write-one clear in the same cycle
    always @* begin
        stat_set = 4'h0;
        stat_clr = 4'h0;
        if (state_r == S_WAIT && adc_valid && out_of_lim) begin
            stat_set[chan_r] = 1'b1;
        end
        if (wr_pend_r && acc_addr_r == `HWM_OFS_STAT) begin
            stat_clr = hwdata[3:0];
        end
        stat_nxt = (stat_r & ~stat_clr) | stat_set;
        alert_nxt = |(stat_nxt & ~mask_nxt);
    end

    // Status, interrupt and alert pins from next-state values

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            stat_r     <= 4'h0;
            irq        <= 1'b0;
            alert_a_o  <= 1'b0;
            alert_a_oe <= 1'b0;
            alert_b_o  <= 1'b0;
            alert_b_oe <= 1'b0;
        end else if (ce) begin
            stat_r     <= stat_nxt;
            irq        <= alert_nxt;
            alert_a_o  <= 1'b0;
            alert_b_o  <= 1'b0;
            alert_a_oe <= ctrl_nxt[`HWM_CTRL_ALERT_A] & alert_nxt;
            alert_b_oe <= ctrl_nxt[`HWM_CTRL_ALERT_B] & alert_nxt;
        end
    end

    // Straps are read only once both synchroniser stages hold pin levels
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            strap_fill_r <= 2'b00;
        end else if (ce) begin
            strap_fill_r <= {strap_fill_r[0], 1'b1};
        end
    end

    // Slave address follows the straps until the first matching transaction
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            slave_addr        <= `HWM_SADDR_DEFAULT;
            slave_addr_locked <= 1'b0;
        end else if (ce && !slave_addr_locked) begin
            if (!strap_fill_r[1]) begin
                slave_addr <= slave_addr;
            end else if (strap_s[0]) begin
                slave_addr <= `HWM_SADDR_DEFAULT;
            end else if (strap_s[1]) begin
                slave_addr <= `HWM_SADDR_SEL_HI;
            end else begin
                slave_addr <= `HWM_SADDR_SEL_LO;
            end
            if (addr_match) begin
                slave_addr_locked <= 1'b1;
            end
        end
    end

endmodule // hwm_core

`default_nettype wire

/* common/hwm_defines.vh */
// Register map, field positions, reset values and address codes of the monitor core
`ifndef HWM_DEFINES_VH
`define HWM_DEFINES_VH

`define HWM_OFS_CTRL        8'h00
`define HWM_OFS_PTR         8'h04
`define HWM_OFS_DATA        8'h08
`define HWM_OFS_STAT        8'h0c
`define HWM_OFS_MASK        8'h10
`define HWM_OFS_VAL         8'h14
`define HWM_OFS_ADDR        8'h18

`define HWM_CTRL_RUN        0
`define HWM_CTRL_ALERT_A    1
`define HWM_CTRL_ALERT_B    2
`define HWM_CTRL_RST        3'h0
`define HWM_MASK_RST        4'h0
`define HWM_PTR_RST         8'h00

`define HWM_IDX_LIM_LO      5'h00
`define HWM_IDX_LIM_HI      5'h04
`define HWM_IDX_OFFSET      5'h08
`define HWM_IDX_FAN_START   5'h0b
`define HWM_IDX_TRANGE      5'h0e
`define HWM_IDX_OPPOINT     5'h11
`define HWM_IDX_ACOUSTIC    5'h14
`define HWM_PROG_DEPTH      32

`define HWM_VLIM_LO_RST     8'h00
`define HWM_VLIM_HI_RST     8'hff
`define HWM_TLIM_LO_RST     8'h80
`define HWM_TLIM_HI_RST     8'h7f

`define HWM_SADDR_SEL_LO    7'h2c
`define HWM_SADDR_SEL_HI    7'h2d
`define HWM_SADDR_DEFAULT   7'h2e

`define HWM_LAST_CHAN       2'h3

`endif

/* core/hwm_sync.v */
// Two-stage synchroniser for asynchronous pin levels
`default_nettype none

module hwm_sync #(
    parameter W = 2
) (
    input  wire         hclk,
    input  wire         hresetn,
    input  wire         ce,
    input  wire [W-1:0] d,
    output wire [W-1:0] q
);

    reg [W-1:0] meta_r;
    reg [W-1:0] sync_r;

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            meta_r <= {W{1'b0}};
            sync_r <= {W{1'b0}};
        end else if (ce) begin
            meta_r <= d;
            sync_r <= meta_r;
        end
    end

    assign q = sync_r;

endmodule // hwm_sync

`default_nettype wire

/* dv/hmlsa_monitor.sv */
// Concurrent checks on the monitor core ports
`default_nettype none
module hmlsa_monitor (
    input wire logic       hclk,
    input wire logic       hresetn,
    input wire logic       ce,
    input wire logic       hsel,
    input wire logic [1:0] htrans,
    input wire logic       hwrite,
    input wire logic       hready,
    input wire logic       hreadyout,
    input wire logic       hresp,
    input wire logic       irq,
    input wire logic       adc_start,
    input wire logic [1:0] adc_chan,
    input wire logic       addr_match,
    input wire logic [6:0] slave_addr,
    input wire logic       slave_addr_locked,
    input wire logic       alert_a_oe,
    input wire logic       alert_b_oe
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    logic [1:0] last_chan_r;
    logic       seen_r;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            last_chan_r <= 2'h0;
            seen_r      <= 1'b0;
        end else if (adc_start) begin
            last_chan_r <= adc_chan;
            seen_r      <= 1'b1;
        end
    end
    a_resp_okay: assert property (hresp == 1'b0)
        else $error("hresp not okay");
    a_read_wait: assert property (ce && hsel && hready && htrans[1] && !hwrite |=> !hreadyout ##1 hreadyout)
        else $error("read wait state wrong");
    a_start_pulse: assert property (adc_start |=> !adc_start)
        else $error("start longer than one cycle");
    a_chan_step: assert property (adc_start && seen_r && adc_chan != 2'h0 |-> adc_chan == last_chan_r + 2'h1)
        else $error("channel order broken");
    a_chan_wrap: assert property (adc_start && seen_r && last_chan_r == 2'h3 |-> adc_chan == 2'h0)
        else $error("sequence did not wrap");
    a_alert_cause: assert property (alert_a_oe || alert_b_oe |-> irq)
        else $error("alert without pending event");
    a_addr_lock: assert property (addr_match && ce && !slave_addr_locked |=> slave_addr_locked)
        else $error("address not locked");
    a_addr_frozen: assert property (slave_addr_locked |=> slave_addr_locked && $stable(slave_addr))
        else $error("locked address changed");
endmodule // hmlsa_monitor
`default_nettype wire

/* dv/hmlsa_adc_model.sv */
// Behavioural converter answering conversion requests
`default_nettype none
module hmlsa_adc_model (
    input  wire logic        hclk,
    input  wire logic        adc_start,
    input  wire logic [1:0]  adc_chan,
    input  wire logic [31:0] samples,
    input  wire logic [3:0]  lat,
    output var  logic [7:0]  adc_data,
    output var  logic        adc_valid
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] res;
    initial begin
        adc_valid = 1'b0;
        adc_data  = 8'h5a;
        forever begin
            @(posedge hclk);
            if (adc_start) begin
                res = samples[{adc_chan, 3'h0} +: 8];
                repeat (lat) @(posedge hclk);
                adc_valid <= 1'b1;
                adc_data  <= res;
                @(posedge hclk);
                adc_valid <= 1'b0;
                adc_data  <= ~res;
            end
        end
    end
endmodule // hmlsa_adc_model
`default_nettype wire

/* dv/hw_monitor_limit_status_alert_tb.sv */
// Self-checking bench for the monitor core
`default_nettype none
module hw_monitor_limit_status_alert_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        hclk = 1'b0, hresetn = 1'b0, ce = 1'b1, hsel = 1'b0, hwrite = 1'b0, addr_match = 1'b0;
    logic        addr_en_pin = 1'b1, addr_sel_pin = 1'b0, hreadyout, hresp, irq, adc_start, adc_valid;
    logic        locked, alert_a_o, alert_a_oe, alert_b_o, alert_b_oe;
    logic [1:0]  htrans = 2'h0, adc_chan;
    logic [2:0]  hsize = 3'h2;
    logic [3:0]  lat = 4'h1;
    logic [6:0]  slave_addr;
    logic [7:0]  adc_data;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, samples = 32'h0, hrdata, rd;
    int          err_total = 0, comparisons = 0, cycles = 0;
    hwm_core u_dut (.hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .irq(irq), .adc_start(adc_start), .adc_chan(adc_chan),
        .adc_data(adc_data), .adc_valid(adc_valid), .addr_en_pin(addr_en_pin), .addr_sel_pin(addr_sel_pin),
        .addr_match(addr_match), .slave_addr(slave_addr), .slave_addr_locked(locked), .alert_a_o(alert_a_o),
        .alert_a_oe(alert_a_oe), .alert_b_o(alert_b_o), .alert_b_oe(alert_b_oe));
    hmlsa_adc_model u_adc (.hclk(hclk), .adc_start(adc_start), .adc_chan(adc_chan), .samples(samples),
        .lat(lat), .adc_data(adc_data), .adc_valid(adc_valid));
    initial begin
        forever #2.5 hclk = ~hclk;
    end
    always @(posedge hclk) begin
        cycles++;
        if (cycles == 5000) begin
            err_total++;
            final_report;
        end
    end
    task final_report;
        $display("comparisons %0d err_total %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask
    // One single transfer at the current hsize; hold each phase until ready is sampled high
    task bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        haddr  <= {24'h0, a};
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    task rdc(input string name, input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(name, exp, rd);
    endtask
    task setp(input logic [31:0] idx, input logic [31:0] val);
        bus(1'b1, 8'h04, idx);
        bus(1'b1, 8'h08, val);
    endtask
    task t_reset;
        rdc("ctrl", 8'h00, 32'h0);
        rdc("mask", 8'h10, 32'h0);
        rdc("addr", 8'h18, 32'h2e);
        bus(1'b1, 8'h1c, 32'hffffffff);
        rdc("unmapped", 8'h1c, 32'h0);
        setp(32'h1, 32'h33);
        setp(32'h4, 32'h44);
        rdc("ptr", 8'h04, 32'h4);
        setp(32'h20, 32'h5a);
        rdc("spare", 8'h08, 32'h0);
    endtask
    task t_prog;
        for (int i = 8; i < 23; i += 3) begin
            setp(i, i ^ 32'ha5);
            rdc("prog", 8'h08, i ^ 32'ha5);
        end
    endtask
    task t_meas;
        setp(32'h1, 32'h0e);
        setp(32'h4, 32'hff);
        setp(32'h8, 32'hfe);
        setp(32'h9, 32'h0);
        setp(32'ha, 32'h0);
        setp(32'h6, 32'h10);
        samples <= 32'h30201040;
        bus(1'b1, 8'h00, 32'h3);
        repeat (30) @(posedge hclk);
        lat <= 4'h9;
        repeat (60) @(posedge hclk);
        rdc("value", 8'h14, 32'h30200e40);
        rdc("status", 8'h0c, 32'h4);
        chk("alert", 32'h6, {29'h0, irq, alert_a_oe, alert_b_oe});
        chk("odrain", 32'h0, {31'h0, alert_a_o | alert_b_o});
    endtask
    task t_mask;
        bus(1'b1, 8'h10, 32'h4);
        repeat (2) @(posedge hclk);
        chk("masked", 32'h0, {30'h0, irq, alert_a_oe});
        bus(1'b1, 8'h10, 32'h0);
        bus(1'b1, 8'h00, 32'h5);
        repeat (2) @(posedge hclk);
        chk("pin_b", 32'h5, {29'h0, irq, alert_a_oe, alert_b_oe});
        bus(1'b1, 8'h00, 32'h4);
        repeat (30) @(posedge hclk);
        bus(1'b1, 8'h0c, 32'h4);
        rdc("cleared", 8'h0c, 32'h0);
        chk("quiet", 32'h0, {30'h0, irq, alert_b_oe});
    endtask
    task t_addr;
        addr_en_pin <= 1'b0;
        repeat (5) @(posedge hclk);
        rdc("sel_lo", 8'h18, 32'h2c);
        addr_sel_pin <= 1'b1;
        repeat (5) @(posedge hclk);
        rdc("sel_hi", 8'h18, 32'h2d);
        addr_match <= 1'b1;
        @(posedge hclk);
        addr_match  <= 1'b0;
        addr_en_pin <= 1'b1;
        repeat (6) @(posedge hclk);
        rdc("locked", 8'h18, 32'had);
        chk("pin", 32'h2d, {25'h0, slave_addr});
    endtask
    // Writes while frozen and narrow writes must leave the mask alone
    task t_freeze;
        ce <= 1'b0;
        bus(1'b1, 8'h10, 32'hf);
        ce <= 1'b1;
        rdc("frozen", 8'h10, 32'h0);
        hsize <= 3'h0;
        bus(1'b1, 8'h10, 32'hf);
        hsize <= 3'h2;
        rdc("narrow", 8'h10, 32'h0);
    endtask
    initial begin
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        t_reset;
        t_prog;
        t_meas;
        t_mask;
        t_addr;
        t_freeze;
        final_report;
    end
endmodule // hw_monitor_limit_status_alert_tb
bind hwm_core hmlsa_monitor u_mon (.hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .htrans(htrans),
    .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .irq(irq), .adc_start(adc_start),
    .adc_chan(adc_chan), .addr_match(addr_match), .slave_addr(slave_addr), .slave_addr_locked(slave_addr_locked),
    .alert_a_oe(alert_a_oe), .alert_b_oe(alert_b_oe));
`default_nettype wire
